// ==== cpmc_core.sv ====
/*
  Current and power monitor core: register file, conversion
  sequencer, averaging, result arithmetic and open-drain alert.
  Assumes a serial front end that delivers pointer and data bytes
  as one-cycle strobes, and ADC codes valid at every clock.
*/
//
// Contract
// RULE_01: Reset leaves the device in continuous mode.
// RULE_02: Continuous mode converts shunt and bus, then current, then power.
// RULE_03: Triggered mode holds results; a config write runs one update.
// RULE_04: Shutdown stops conversions but registers stay reachable.
// RULE_05: Shutdown holds until a continuous or triggered mode is written.
// RULE_06: Shunt and bus conversion times are selectable, 139 us to 8.205 ms.
// RULE_07: Config holds an averaging count applied before results update.
// RULE_08: A config control bit resets every register to default.
// RULE_09: Current equals signed shunt times calibration over 2048.
// RULE_10: Power equals bus times current over 20000.
// RULE_11: Power is computed only after current is updated.
// RULE_12: Current and power read zero until the first update.
// RULE_13: Host programs calibration as 0.00512 over shunt times current LSB.
// RULE_14: Selected quantity past the limit pulls the alert pin low.
// RULE_15: Five checks: shunt over, shunt under, bus over, bus under, power over.
// RULE_16: Alert may also signal conversion ready.
// RULE_17: With several checks enabled, the most significant one wins.
// RULE_18: Limit comparisons are signed.
// RULE_19: Mask register shows conversion ready at bit 3, alert flag at bit 4.
// RULE_20: Reads send MSB then LSB of the retained pointer register.
// RULE_21: Conversion ready sets on each update, clears on mask read.
`timescale 1ns/1ps
module cpmc_core
  import cpmc_pkg::*;
#(
  parameter int CT_MIN_CYCLES = CT_MIN_CYC,
  parameter int CT_MAX_CYCLES = CT_MAX_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [15:0] adc_shunt_code,
  input  wire logic [15:0] adc_bus_code,
  input  wire logic        host_xfer_start,
  input  wire logic        host_ptr_wr,
  input  wire logic        host_byte_wr,
  input  wire logic        host_rd_next,
  input  wire logic [7:0]  host_wdata,
  output logic      [7:0]  host_rdata,
  output logic             host_rdata_valid,
  output logic             alert_out,
  output logic             alert_oe
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  cpmc_state_t        state_reg;
  cpmc_state_t        state_next;
  logic               soft_rst_reg;
  logic               rst_all;
  logic [7:0]         ptr_reg;
  logic               phase_reg;
  logic [7:0]         wr_msb_reg;
  logic [7:0]         rd_lsb_reg;
  logic [7:0]         rdata_reg;
  logic               rvalid_reg;
  logic               wr_commit;
  logic [15:0]        wr_word;
  logic [15:0]        cfg_reg;
  logic [15:0]        cal_reg;
  logic [15:0]        mask_reg;
  logic [15:0]        limit_reg;
  logic               cfg_wr_reg;
  logic [19:0]        timer_reg;
  logic [10:0]        avg_cnt_reg;
  logic signed [25:0] sh_acc_reg;
  logic [25:0]        bus_acc_reg;
  logic signed [25:0] sh_sum;
  logic [25:0]        bus_sum;
  logic [15:0]        shunt_reg;
  logic [15:0]        bus_reg;
  logic [15:0]        current_reg;
  logic [15:0]        power_reg;
  logic               conv_ready_flag_reg;
  logic               aff_reg;
  logic               alert_oe_reg;
  logic               alert_out_reg;
  logic [15:0]        current_val;
  logic [15:0]        power_val;
  logic               limit_hit;
  logic               seq_start;
  logic               avg_last;
  logic [3:0]         avg_sh;
  logic               mask_rd;
  logic               rd_take;
  logic [15:0]        rd_word;
  logic               calc_busy;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Mode low bits zero means shutdown; bit 2 selects continuous
  function automatic logic is_shutdown(input logic [15:0] cfg);
    return cfg[CFG_MODE_LSB+1 -: 2] == 2'b00;
  endfunction : is_shutdown

  function automatic logic is_cont(input logic [15:0] cfg);
    return cfg[CFG_MODE_LSB+2] && !is_shutdown(cfg);
  endfunction : is_cont

  // Eight evenly spread conversion times between the two ends
  function automatic logic [19:0] ct_cycles(input logic [2:0] code);
    int span;
    span = CT_MIN_CYCLES + int'(code) * (CT_MAX_CYCLES - CT_MIN_CYCLES)
           / CT_STEPS;
    return 20'(span - 1);
  endfunction : ct_cycles

  // Averaging counts 1,4,16,64,128,256,512,1024 as shift amounts
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0:    return 4'h0;
      3'h1:    return 4'h2;
      3'h2:    return 4'h4;
      3'h3:    return 4'h6;
      3'h4:    return 4'h7;
      3'h5:    return 4'h8;
      3'h6:    return 4'h9;
      default: return 4'hA;
    endcase
  endfunction : avg_shift

  function automatic logic [15:0] reg_value(input logic [7:0] ptr);
    case (ptr)
      REG_CONFIG: return cfg_reg;
      REG_SHUNT:  return shunt_reg;
      REG_BUS:    return bus_reg;
      REG_POWER:  return power_reg;
      REG_CURR:   return current_reg;
      REG_CAL:    return cal_reg;
      REG_MASK:   return mask_reg;
      REG_LIMIT:  return limit_reg;
      default:    return ZERO_RESET;
    endcase
  endfunction : reg_value

  // ---------------------------------------------------------------
  // Software reset
  // ---------------------------------------------------------------
  // One-cycle pulse; stretching it is pointless, every register
  // takes its default on the next edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_commit && ptr_reg == REG_CONFIG
                      && wr_word[CFG_RST_BIT]; // [RULE_08]
    end
  end

  assign rst_all = srst | soft_rst_reg;

  // ---------------------------------------------------------------
  // Byte port: pointer, write pairing, read sequencing
  // ---------------------------------------------------------------
  assign wr_commit = host_byte_wr && phase_reg && !host_xfer_start
                     && !host_ptr_wr;
  assign wr_word   = {wr_msb_reg, host_wdata};
  // A read strobe counts only when no stronger strobe shares its cycle
  assign rd_take   = host_rd_next && !host_xfer_start && !host_ptr_wr
                     && !host_byte_wr;
  assign mask_rd   = rd_take && !phase_reg && ptr_reg == REG_MASK;

  // Word behind the pointer, for the MSB fetch and its check
  always_comb begin
    rd_word = reg_value(ptr_reg);
  end

  // Pointer survives between transfers; phase restarts per transfer
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      ptr_reg    <= 8'h00;
      phase_reg  <= 1'b0;
      wr_msb_reg <= 8'h00;
    end else if (host_xfer_start) begin
      phase_reg <= 1'b0;
    end else if (host_ptr_wr) begin
      ptr_reg   <= host_wdata;
      phase_reg <= 1'b0;
    end else if (host_byte_wr) begin
      wr_msb_reg <= host_wdata;
      phase_reg  <= ~phase_reg;
    end else if (host_rd_next) begin
      phase_reg <= ~phase_reg;
    end
  end

  // MSB goes out first; LSB is frozen so both halves match
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      rdata_reg  <= 8'h00;
      rd_lsb_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_take;
      if (rd_take && !phase_reg) begin
        rdata_reg  <= rd_word[15:8]; // [RULE_20]
        rd_lsb_reg <= rd_word[7:0];
      end else if (rd_take) begin
        rdata_reg <= rd_lsb_reg; // [RULE_20]
      end
    end
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  // Reset bit never stores, so it always reads back zero
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      cfg_reg    <= CFG_RESET; // [RULE_01] [RULE_08]
      cfg_wr_reg <= 1'b0;
    end else begin
      // A trigger is held while current and power are in flight
      cfg_wr_reg <= cfg_wr_reg && calc_busy;
      if (wr_commit && ptr_reg == REG_CONFIG && !wr_word[CFG_RST_BIT]) begin
        cfg_reg    <= wr_word; // [RULE_06] [RULE_07]
        cfg_wr_reg <= 1'b1; // [RULE_03]
      end
    end
  end

  // Calibration and limit are plain storage
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      cal_reg   <= ZERO_RESET;
      limit_reg <= ZERO_RESET;
    end else if (wr_commit && ptr_reg == REG_CAL) begin
      cal_reg <= wr_word;
    end else if (wr_commit && ptr_reg == REG_LIMIT) begin
      limit_reg <= wr_word;
    end
  end

  // Only the enable bits are writable; flags come from hardware
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      mask_reg <= ZERO_RESET;
    end else begin
      if (wr_commit && ptr_reg == REG_MASK) begin
        mask_reg[15:MSK_CONV_READY_ALERT_ENABLE_BIT] <= wr_word[15:MSK_CONV_READY_ALERT_ENABLE_BIT]; // [RULE_15]
      end
      mask_reg[MSK_AFF_BIT]  <= aff_reg; // [RULE_19]
      mask_reg[MSK_CONV_READY_FLAG_BIT] <= conv_ready_flag_reg; // [RULE_19]
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  assign avg_sh   = avg_shift(cfg_reg[CFG_AVG_LSB+2 -: 3]);
  assign avg_last = avg_cnt_reg == 11'((12'h001 << avg_sh) - 12'h001);

  // Calculation steps finish before a restart, so each power value
  // pairs with the current of its own run
  assign calc_busy = state_reg == ST_CURR || state_reg == ST_POWER
                     || state_reg == ST_DONE; // [RULE_11]

  // A config write restarts the run, which also serves as trigger
  always_comb begin
    state_next = state_reg;
    if (cfg_wr_reg && !calc_busy) begin
      state_next = is_shutdown(cfg_reg) ? ST_IDLE : ST_SHUNT; // [RULE_05]
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (is_cont(cfg_reg)) begin
            state_next = ST_SHUNT; // [RULE_02] [RULE_04]
          end
        end
        ST_SHUNT: begin
          if (timer_reg == 20'h00000) begin
            state_next = ST_BUS;
          end
        end
        ST_BUS: begin
          if (timer_reg == 20'h00000) begin
            state_next = avg_last ? ST_CURR : ST_SHUNT; // [RULE_07]
          end
        end
        ST_CURR:  state_next = ST_POWER; // [RULE_11]
        ST_POWER: state_next = ST_DONE;
        ST_DONE:  state_next = ST_IDLE;
        default:  state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign seq_start = state_next == ST_SHUNT
                     && (cfg_wr_reg || state_reg == ST_IDLE);

  // Each channel waits its own selected conversion time
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      timer_reg <= 20'h00000;
    end else if (state_next == ST_SHUNT && state_reg != ST_SHUNT
                 || seq_start) begin
      timer_reg <= ct_cycles(cfg_reg[CFG_VST_LSB+2 -: 3]); // [RULE_06]
    end else if (state_next == ST_BUS && state_reg != ST_BUS) begin
      timer_reg <= ct_cycles(cfg_reg[CFG_VBT_LSB+2 -: 3]); // [RULE_06]
    end else if (timer_reg != 20'h00000) begin
      timer_reg <= timer_reg - 20'h00001;
    end
  end

  // ---------------------------------------------------------------
  // Averaging and result registers
  // ---------------------------------------------------------------
  assign sh_sum  = sh_acc_reg + 26'(signed'(adc_shunt_code));
  assign bus_sum = bus_acc_reg + {10'h000, adc_bus_code};

  // Power-of-two counts, so averaging is a shift, not a divide
  always_ff @(posedge sys_clk) begin
    if (rst_all || seq_start) begin
      sh_acc_reg  <= 26'h0000000;
      bus_acc_reg <= 26'h0000000;
      avg_cnt_reg <= 11'h000;
    end else if (timer_reg == 20'h00000 && state_reg == ST_SHUNT) begin
      sh_acc_reg <= sh_sum;
    end else if (timer_reg == 20'h00000 && state_reg == ST_BUS) begin
      bus_acc_reg <= bus_sum;
      avg_cnt_reg <= avg_cnt_reg + 11'h001;
    end
  end

  // Results move only at the end of a full averaging run
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      shunt_reg <= ZERO_RESET;
      bus_reg   <= ZERO_RESET;
    end else if (state_reg == ST_BUS && state_next == ST_CURR) begin
      shunt_reg <= 16'(sh_acc_reg >>> avg_sh); // [RULE_07]
      bus_reg   <= 16'(bus_sum >> avg_sh);
    end
  end

  // Current first, power one cycle later from the fresh current
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      current_reg <= ZERO_RESET; // [RULE_12]
      power_reg   <= ZERO_RESET; // [RULE_12]
    end else if (state_reg == ST_CURR) begin
      current_reg <= current_val; // [RULE_09]
    end else if (state_reg == ST_POWER) begin
      power_reg <= power_val; // [RULE_10] [RULE_11]
    end
  end

  cpmc_result_math u_math (
    .shunt_code   (shunt_reg),
    .bus_code     (bus_reg),
    .cal_code     (cal_reg),
    .current_code (current_reg),
    .current_val  (current_val),
    .power_val    (power_val)
  );

  // ---------------------------------------------------------------
  // Flags and alert
  // ---------------------------------------------------------------
  cpmc_limit_check u_limit (
    .limit_sel  (mask_reg[15:MSK_SEL_LSB]),
    .shunt_code (shunt_reg),
    .bus_code   (bus_reg),
    .power_code (power_reg),
    .limit_code (limit_reg),
    .limit_hit  (limit_hit)
  );

  // Ready flag: a completion in the read cycle beats the clear
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      conv_ready_flag_reg <= 1'b0;
      aff_reg  <= 1'b0;
    end else begin
      if (state_reg == ST_DONE) begin
        conv_ready_flag_reg <= 1'b1; // [RULE_21]
        aff_reg  <= limit_hit; // [RULE_14] [RULE_17] [RULE_18]
      end else if (mask_rd) begin
        conv_ready_flag_reg <= 1'b0; // [RULE_21]
      end
    end
  end

  // Pin level is always low; only the enable toggles, as open drain
  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      alert_oe_reg  <= 1'b0;
      alert_out_reg <= 1'b0;
    end else begin
      alert_out_reg <= 1'b0;
      alert_oe_reg  <= (aff_reg && |mask_reg[15:MSK_SEL_LSB]) // [RULE_14]
                       || (mask_reg[MSK_CONV_READY_ALERT_ENABLE_BIT] && conv_ready_flag_reg); // [RULE_16]
    end
  end

  assign host_rdata       = rdata_reg;
  assign host_rdata_valid = rvalid_reg;
  assign alert_out        = alert_out_reg;
  assign alert_oe         = alert_oe_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic updated_reg;

  always_ff @(posedge sys_clk) begin
    if (rst_all) begin
      updated_reg <= 1'b0;
    end else if (state_reg == ST_CURR) begin
      updated_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  // Soft reset ends every attempt too; the reset check opts out
  default disable iff (rst_all);

  sequence s_calc;
    state_reg == ST_CURR ##1 state_reg == ST_POWER ##1 state_reg == ST_DONE;
  endsequence

  chk_reset_cont: assert property ( // [RULE_01]
    $fell(srst) |-> state_reg == ST_IDLE ##1 state_reg == ST_SHUNT)
    else $error("continuous run not started after reset");
  chk_calc_order: assert property ( // [RULE_11]
    state_reg == ST_BUS && state_next == ST_CURR |=> s_calc)
    else $error("current, power, done order broken");
  chk_shdn_hold: assert property ( // [RULE_04]
    state_reg == ST_IDLE && is_shutdown(cfg_reg) && !cfg_wr_reg
    |=> state_reg == ST_IDLE)
    else $error("conversion started in shutdown");
  chk_trig_hold: assert property ( // [RULE_03]
    state_reg == ST_IDLE && !is_cont(cfg_reg) && !cfg_wr_reg
    |=> $stable(shunt_reg) && $stable(bus_reg) && state_reg == ST_IDLE)
    else $error("results moved in triggered mode");
  chk_curr_math: assert property ( // [RULE_09]
    state_reg == ST_CURR |=> current_reg == 16'(($signed($past(shunt_reg))
      * $signed({17'h00000, $past(cal_reg)})) >>> 11))
    else $error("current result mismatch");
  chk_zero_init: assert property ( // [RULE_12]
    !updated_reg |-> current_reg == 16'h0000 && power_reg == 16'h0000)
    else $error("result nonzero before first update");
  chk_conv_ready_flag_set: assert property ( // [RULE_21]
    state_reg == ST_DONE |=> conv_ready_flag_reg ##1 mask_reg[MSK_CONV_READY_FLAG_BIT])
    else $error("conversion ready not flagged");
  chk_conv_ready_alert_enable_alert: assert property ( // [RULE_16]
    mask_reg[MSK_CONV_READY_ALERT_ENABLE_BIT] && conv_ready_flag_reg && !soft_rst_reg |=> alert_oe)
    else $error("ready did not drive alert");
  chk_sw_reset: assert property (disable iff (srst) // [RULE_08]
    wr_commit && ptr_reg == REG_CONFIG && wr_word[CFG_RST_BIT]
    |=> ##1 cfg_reg == CFG_RESET && cal_reg == 16'h0000)
    else $error("software reset ignored");
  chk_read_msb: assert property ( // [RULE_20]
    rd_take && !phase_reg
    |=> host_rdata_valid && host_rdata == $past(rd_word[15:8]))
    else $error("read did not start with MSB");

endmodule : cpmc_core

// ==== cpmc_pkg.sv ====
/*
  Constants shared by the current and power monitor core.
  Assumes a 100 MHz sys_clk and a byte-wide register port.
*/
package cpmc_pkg;

  // ---------------------------------------------------------------
  // Register pointers
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_SHUNT  = 8'h01;
  localparam logic [7:0] REG_BUS    = 8'h02;
  localparam logic [7:0] REG_POWER  = 8'h03;
  localparam logic [7:0] REG_CURR   = 8'h04;
  localparam logic [7:0] REG_CAL    = 8'h05;
  localparam logic [7:0] REG_MASK   = 8'h06;
  localparam logic [7:0] REG_LIMIT  = 8'h07;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [15:0] CFG_RESET   = 16'h4127;
  localparam logic [15:0] ZERO_RESET  = 16'h0000;
  localparam int CFG_RST_BIT  = 15;
  localparam int CFG_AVG_LSB  = 9;
  localparam int CFG_VBT_LSB  = 6;
  localparam int CFG_VST_LSB  = 3;
  localparam int CFG_MODE_LSB = 0;
  localparam int MSK_SEL_LSB  = 11;
  localparam int MSK_CONV_READY_ALERT_ENABLE_BIT = 10;
  localparam int MSK_AFF_BIT  = 4;
  localparam int MSK_CONV_READY_FLAG_BIT = 3;

  // ---------------------------------------------------------------
  // Timing and arithmetic
  // ---------------------------------------------------------------
  localparam int CLK_NS     = 10;
  localparam int CT_MIN_NS  = 139000;
  localparam int CT_MAX_NS  = 8205000;
  localparam int CT_MIN_CYC = (CT_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int CT_MAX_CYC = CT_MAX_NS / CLK_NS;
  localparam int CT_STEPS   = 7;
  localparam int CURR_SHIFT = 11;
  localparam logic [31:0] POWER_DIV = 32'd20000;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHUNT = 3'b001,
    ST_BUS   = 3'b010,
    ST_CURR  = 3'b011,
    ST_POWER = 3'b100,
    ST_DONE  = 3'b101
  } cpmc_state_t;

endpackage : cpmc_pkg

// ==== cpmc_result_math.sv ====
/*
  Current and power arithmetic of the monitor core.
  Purely combinational; the caller sequences current before power.
*/
`timescale 1ns/1ps
module cpmc_result_math
  import cpmc_pkg::*;
(
  input  wire logic [15:0] shunt_code,
  input  wire logic [15:0] bus_code,
  input  wire logic [15:0] cal_code,
  input  wire logic [15:0] current_code,
  output logic      [15:0] current_val,
  output logic      [15:0] power_val
);

  logic signed [32:0] i_prod;
  logic        [31:0] i_mag;
  logic        [31:0] p_prod;
  logic        [31:0] p_quot;

  // ---------------------------------------------------------------
  // Signed shunt times calibration over 2048, then bus times current
  // ---------------------------------------------------------------
  always_comb begin
    i_prod      = $signed(shunt_code) * $signed({1'b0, cal_code});
    current_val = i_prod[CURR_SHIFT+15:CURR_SHIFT];
    // Power is reported as a magnitude, so a reversed current counts too
    i_mag  = {16'h0000, current_code[15] ? 16'(~current_code + 16'h0001)
                                         : current_code};
    p_prod = {16'h0000, bus_code} * i_mag;
    p_quot = p_prod / POWER_DIV;
    // Saturate instead of wrapping on extreme settings
    power_val = (p_quot > 32'h0000FFFF) ? 16'hFFFF : p_quot[15:0];
  end

endmodule : cpmc_result_math

// ==== cpmc_limit_check.sv ====
/*
  Limit comparator of the monitor core.
  Enables arrive as five bits, most significant one first in priority.
*/
`timescale 1ns/1ps
module cpmc_limit_check
  import cpmc_pkg::*;
(
  input  wire logic [4:0]  limit_sel,
  input  wire logic [15:0] shunt_code,
  input  wire logic [15:0] bus_code,
  input  wire logic [15:0] power_code,
  input  wire logic [15:0] limit_code,
  output logic             limit_hit
);

  logic signed [15:0] lim;

  // ---------------------------------------------------------------
  // Signed compare; only the highest enabled check is used
  // ---------------------------------------------------------------
  always_comb begin
    lim = $signed(limit_code);
    if (limit_sel[4]) begin
      limit_hit = $signed(shunt_code) > lim;
    end else if (limit_sel[3]) begin
      limit_hit = $signed(shunt_code) < lim;
    end else if (limit_sel[2]) begin
      limit_hit = $signed(bus_code) > lim;
    end else if (limit_sel[1]) begin
      limit_hit = $signed(bus_code) < lim;
    end else if (limit_sel[0]) begin
      limit_hit = $signed(power_code) > lim;
    end else begin
      limit_hit = 1'b0;
    end
  end

endmodule : cpmc_limit_check

// ==== cpmc_host_model.sv ====
/*
  Host model of the serial register port: word writes and reads.
  Assumes the core clock and the byte-strobe port of the core.
*/
`timescale 1ns/1ps
module cpmc_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_rdata_valid,
  output logic            host_xfer_start,
  output logic            host_ptr_wr,
  output logic            host_byte_wr,
  output logic            host_rd_next,
  output logic [7:0]      host_wdata
);
  // ------------------------------------------------------------
  // Byte strobes
  // ------------------------------------------------------------
  initial begin
    {host_xfer_start, host_ptr_wr, host_byte_wr, host_rd_next} = 4'h0;
    host_wdata = 8'h00;
  end
  // Data flips after each strobe so a stale byte never looks valid
  task automatic pulse(input int kind, input logic [7:0] b);
    @(negedge sys_clk);
    host_wdata = b;
    case (kind)
      0: host_xfer_start = 1'b1;
      1: host_ptr_wr = 1'b1;
      2: host_byte_wr = 1'b1;
      default: host_rd_next = 1'b1;
    endcase
    @(negedge sys_clk);
    {host_xfer_start, host_ptr_wr, host_byte_wr, host_rd_next} = 4'h0;
    host_wdata = ~b;
  endtask : pulse
  // Word write: pointer, then MSB, then LSB
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    pulse(0, 8'h00);
    pulse(1, p);
    pulse(2, d[15:8]);
    pulse(2, d[7:0]);
  endtask : wr
  // Word read; a missing valid leaves unknown bits to be caught
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    pulse(0, 8'h00);
    pulse(1, p);
    pulse(3, 8'h00);
    d[15:8] = host_rdata_valid ? host_rdata : 8'hXX;
    pulse(3, 8'h00);
    d[7:0] = host_rdata_valid ? host_rdata : 8'hXX;
  endtask : rd
endmodule : cpmc_host_model

// ==== cpmc_core_test.sv ====
/*
  Self-checking bench of the monitor core.
  Assumes short conversion times (4 to 11 cycles) for speed.
*/
`timescale 1ns/1ps
module cpmc_core_test;
  import cpmc_pkg::*;
  logic        sys_clk, srst, xs, pw, bw, rn, rv, aout, aoe;
  logic [15:0] shunt, bus, r;
  logic [7:0]  wd, rdat;
  int          bad_count, compares;
  cpmc_host_model host (.sys_clk(sys_clk), .host_rdata(rdat), .host_rdata_valid(rv),
    .host_xfer_start(xs), .host_ptr_wr(pw), .host_byte_wr(bw), .host_rd_next(rn),
    .host_wdata(wd));
  cpmc_core #(.CT_MIN_CYCLES(4), .CT_MAX_CYCLES(11)) DUT (.sys_clk(sys_clk),
    .srst(srst), .adc_shunt_code(shunt), .adc_bus_code(bus), .host_xfer_start(xs),
    .host_ptr_wr(pw), .host_byte_wr(bw), .host_rd_next(rn), .host_wdata(wd),
    .host_rdata(rdat), .host_rdata_valid(rv), .alert_out(aout), .alert_oe(aoe));
  // ------------------------------------------------------------
  // Clock, helpers
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] p, input logic [15:0] exp);
    host.rd(p, r);
    chk(r, exp);
  endtask : rchk
  // Waits end on a falling edge so inputs change off the sampling edge
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic conclude;
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_math;
    rchk(REG_CONFIG, CFG_RESET);
    rchk(REG_CURR, 16'h0000);
    rchk(REG_POWER, 16'h0000);
    host.wr(REG_CAL, 16'h0A00);
    idle(60);
    rchk(REG_SHUNT, 16'h1F40);
    rchk(REG_CURR, 16'h2710);
    rchk(REG_POWER, 16'h12C0);
  endtask : t_math
  // Triggered holds results; each config write runs one update
  task automatic t_trig;
    host.wr(REG_CONFIG, 16'h4123);
    idle(60);
    shunt = 16'h0100;
    idle(60);
    rchk(REG_SHUNT, 16'h1F40);
    host.wr(REG_CONFIG, 16'h4323);
    idle(150);
    rchk(REG_SHUNT, 16'h0100);
  endtask : t_trig
  task automatic t_shut;
    host.wr(REG_CONFIG, 16'h4120);
    shunt = 16'h0200;
    idle(80);
    rchk(REG_SHUNT, 16'h0100);
    rchk(REG_CAL, 16'h0A00);
    host.wr(REG_CONFIG, 16'h4127);
    idle(60);
    rchk(REG_SHUNT, 16'h0200);
  endtask : t_shut
  // Over and under both enabled: over wins, compared signed
  task automatic t_alert;
    host.wr(REG_LIMIT, 16'h0001);
    shunt = 16'hFFF0;
    host.wr(REG_MASK, 16'hC000);
    idle(60);
    chk({15'h0000, aoe}, 16'h0000);
    rchk(REG_MASK, 16'hC008);
    shunt = 16'h0005;
    idle(60);
    chk({15'h0000, aoe}, 16'h0001);
    chk({15'h0000, aout}, 16'h0000);
    rchk(REG_MASK, 16'hC018);
    host.wr(REG_MASK, 16'h0400);
    idle(60);
    chk({15'h0000, aoe}, 16'h0001);
    host.wr(REG_MASK, 16'h2000);
    idle(60);
    chk({15'h0000, aoe}, 16'h0001);
    host.wr(REG_MASK, 16'h1000);
    idle(60);
    chk({15'h0000, aoe}, 16'h0000);
    host.wr(REG_MASK, 16'h0800);
    idle(60);
    chk({15'h0000, aoe}, 16'h0001);
  endtask : t_alert
  task automatic t_swrst;
    host.wr(REG_CONFIG, 16'h8000);
    idle(4);
    rchk(REG_CONFIG, CFG_RESET);
    rchk(REG_CAL, 16'h0000);
    rchk(REG_LIMIT, 16'h0000);
  endtask : t_swrst
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    bad_count = 0;
    compares = 0;
    srst = 1'b1;
    shunt = 16'h1F40;
    bus = 16'h2580;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    t_math();
    t_trig();
    t_shut();
    t_alert();
    t_swrst();
    conclude();
  end
  initial begin
    repeat (8000) @(posedge sys_clk);
    bad_count++;
    conclude();
  end
endmodule : cpmc_core_test
